/* File: rtl/daq_arbiter_queue.sv */
// arbiter queue with hazard tracking, read QoS and refresh time-out
module daq_arbiter_queue
   import daq_pkg::*;
#(
   parameter int  NUM_ENTRIES = DAQ_DEPTH,
   localparam int IW          = (NUM_ENTRIES > 1) ? $clog2(NUM_ENTRIES) : 1
)(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic [31:0]                 hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   input  wire logic                   dreq_valid,
   input  wire daq_dreq_s              dreq,
   output logic                        dreq_ready,
   input  wire daq_wdat_s              wdat,
   input  wire logic [DAQ_NUM_PID-1:0] qos_override,
   output logic                        gnt_valid,
   output daq_gnt_s                    gnt,
   output logic [IW-1:0]               gnt_idx,
   input  wire logic                   gnt_ready,
   input  wire logic                   done_valid,
   input  wire logic [IW-1:0]          done_idx,
   output logic                        rsp_valid,
   output daq_rsp_s                    rsp
);
   localparam int N  = NUM_ENTRIES;

   // lowest set index of a vector; shared by slot allocation and arbitration
   function automatic logic [IW-1:0] first_idx(input logic [N-1:0] v);
      first_idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            first_idx = IW'(i);
         end
      end
   endfunction : first_idx

   ////////////////////////////////////////////////////////////////////////////
   // register file over AHB-Lite, zero wait state
   logic [2:0]  qmb_ff, nxt_qmb;
   logic        pause_ff, nxt_pause;
   logic [15:0] prd_ff, nxt_prd;
   logic [7:0]  mor_ff, nxt_mor;
   logic [2:0]  chips_ff, nxt_chips;
   logic [15:0] pid_ff [DAQ_NUM_PID];
   logic [15:0] nxt_pid [DAQ_NUM_PID];
   logic        wpend_ff, nxt_wpend;
   logic [11:0] waddr_ff, nxt_waddr;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic        hready_ff;
   logic        hresp_ff;
   logic        ref_to_ff;
   logic [7:0]  rcnt_ff;
   daq_ent_s    ent_ff [N];
   logic [N-1:0] vmask;
   logic [7:0]  occ;

   // read data is captured in the address phase so the data phase needs no wait
   always_comb begin
      logic access;
      access     = hsel && hready && htrans[1];
      nxt_qmb    = qmb_ff;
      nxt_pause  = pause_ff;
      nxt_prd    = prd_ff;
      nxt_mor    = mor_ff;
      nxt_chips  = chips_ff;
      nxt_pid    = pid_ff;
      nxt_wpend  = 1'b0;
      nxt_waddr  = waddr_ff;
      nxt_hrdata = hrdata_ff;
      if (wpend_ff) begin
         if (waddr_ff == DAQ_OFF_CTRL) begin
            nxt_qmb   = hwdata[2:0];
            nxt_pause = hwdata[DAQ_CTRL_PAUSE];
         end else if (waddr_ff == DAQ_OFF_REFPRD) begin
            nxt_prd = hwdata[15:0];
         end else if (waddr_ff == DAQ_OFF_REFCFG) begin
            nxt_mor   = hwdata[7:0];
            nxt_chips = hwdata[DAQ_REFCFG_CHIPS +: 3];
         end else if (waddr_ff[11:6] == DAQ_PID_PAGE) begin
            nxt_pid[waddr_ff[5:2]] = hwdata[15:0];
         end
      end
      if (access) begin
         nxt_wpend  = hwrite;
         nxt_waddr  = {haddr[11:2], 2'b00};
         nxt_hrdata = 32'h0000_0000;
         if (haddr[11:2] == DAQ_OFF_CTRL[11:2]) begin
            nxt_hrdata[2:0]            = qmb_ff;
            nxt_hrdata[DAQ_CTRL_PAUSE] = pause_ff;
         end else if (haddr[11:2] == DAQ_OFF_REFPRD[11:2]) begin
            nxt_hrdata[15:0] = prd_ff;
         end else if (haddr[11:2] == DAQ_OFF_REFCFG[11:2]) begin
            nxt_hrdata[7:0]                   = mor_ff;
            nxt_hrdata[DAQ_REFCFG_CHIPS +: 3] = chips_ff;
         end else if (haddr[11:2] == DAQ_OFF_STATUS[11:2]) begin
            nxt_hrdata[7:0]               = occ;
            nxt_hrdata[DAQ_STAT_REFTO]    = ref_to_ff;
            nxt_hrdata[DAQ_STAT_PAUSE]    = pause_ff;
            nxt_hrdata[DAQ_STAT_RCNT +: 8] = rcnt_ff;
         end else if (haddr[11:2] == DAQ_OFF_VALID[11:2]) begin
            nxt_hrdata[N-1:0] = vmask;
         end else if (haddr[11:6] == DAQ_PID_PAGE) begin
            nxt_hrdata[15:0] = pid_ff[haddr[5:2]];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         qmb_ff    <= DAQ_RST_QMB;
         pause_ff  <= 1'b0;
         prd_ff    <= DAQ_RST_PRD;
         mor_ff    <= DAQ_RST_MOR;
         chips_ff  <= DAQ_RST_CHIPS;
         for (int i = 0; i < DAQ_NUM_PID; i++) begin
            pid_ff[i] <= DAQ_RST_PID;
         end
         wpend_ff  <= 1'b0;
         waddr_ff  <= 12'h000;
         hrdata_ff <= 32'h0000_0000;
         hready_ff <= 1'b1;
         hresp_ff  <= 1'b0;
      end else begin
         qmb_ff    <= nxt_qmb;
         pause_ff  <= nxt_pause;
         prd_ff    <= nxt_prd;
         mor_ff    <= nxt_mor;
         chips_ff  <= nxt_chips;
         pid_ff    <= nxt_pid;
         wpend_ff  <= nxt_wpend;
         waddr_ff  <= nxt_waddr;
         hrdata_ff <= nxt_hrdata;
         hready_ff <= 1'b1; // never stretches a transfer
         hresp_ff  <= 1'b0; // always OKAY
      end
   end

   assign hrdata    = hrdata_ff;
   assign hreadyout = hready_ff;
   assign hresp     = hresp_ff;

   ////////////////////////////////////////////////////////////////////////////
   // refresh request source
   logic       rreq_valid;
   logic [1:0] rreq_chip;
   logic       rreq_ack;

   daq_refresh_gen u_refgen (
      .clk       (clk),
      .nrst      (nrst),
      .prd       (prd_ff),
      .chips     (chips_ff),
      .req_valid (rreq_valid),
      .req_chip  (rreq_chip),
      .req_ack   (rreq_ack)
   );

   ////////////////////////////////////////////////////////////////////////////
   // queue state
   daq_ent_s     nxt_ent [N];
   logic [N-1:0] dep_ff [N];
   logic [N-1:0] nxt_dep [N];
   logic         hold_ff, nxt_hold;
   daq_dreq_s    hreq_ff, nxt_hreq;
   logic         dready_ff, nxt_dready;
   logic [7:0]   wid_ff, nxt_wid;
   logic         widv_ff, nxt_widv;
   logic         gv_ff, nxt_gv;
   daq_gnt_s     g_ff, nxt_g;
   logic [IW-1:0] gi_ff, nxt_gi;
   logic         rv_ff, nxt_rv;
   daq_rsp_s     r_ff, nxt_r;
   logic [7:0]   nxt_rcnt;
   logic         nxt_ref_to;

   always_comb begin
      occ = 8'h00;
      for (int i = 0; i < N; i++) begin
         vmask[i] = ent_ff[i].valid;
         occ      = occ + {7'h00, ent_ff[i].valid};
      end
   end

   always_comb begin
      logic [N-1:0] live, tmin, tmax, elig, emin, emax, tany;
      logic [IW-1:0] slot, pick;
      logic         ins, ins_ref, rinc, rdec;
      logic [3:0]   s;
      logic [15:0]  cfg;
      nxt_ent    = ent_ff;
      nxt_dep    = dep_ff;
      nxt_hold   = hold_ff;
      nxt_hreq   = hreq_ff;
      nxt_wid    = wid_ff;
      nxt_widv   = widv_ff;
      nxt_gv     = gv_ff;
      nxt_g      = g_ff;
      nxt_gi     = gi_ff;
      nxt_rv     = 1'b0;
      nxt_r      = r_ff;
      rreq_ack   = 1'b0;
      rinc       = 1'b0;
      rdec       = 1'b0;
      s          = 4'h0;
      cfg        = 16'h0000;
      {live, tmin, tmax, elig, emin, emax, tany, slot, pick, ins, ins_ref} = '0;
      // time-out classes seen this cycle
      for (int i = 0; i < N; i++) begin
         tmin[i] = ent_ff[i].valid && ent_ff[i].minf;
         tmax[i] = ent_ff[i].valid && ((ent_ff[i].qen && ent_ff[i].maxc == 8'h00)
                   || ent_ff[i].forced || (ent_ff[i].refr && ref_to_ff));
         tany[i] = tmin[i] || tmax[i];
         elig[i] = ent_ff[i].valid && (dep_ff[i] == '0) && (ent_ff[i].remain != 8'h00)
                   && (!ent_ff[i].wr || ent_ff[i].wready);
      end
      emin = elig & tmin;
      emax = elig & tmax;
      // removal after the last burst's data has crossed the memory side
      live = vmask;
      if (done_valid && ent_ff[done_idx].valid) begin
         live[done_idx]          = 1'b0;
         nxt_ent[done_idx].valid = 1'b0;
         nxt_rv  = !ent_ff[done_idx].refr;
         nxt_r   = '{wr: ent_ff[done_idx].wr, id: ent_ff[done_idx].id};
         rdec    = ent_ff[done_idx].refr;
         for (int j = 0; j < N; j++) begin
            nxt_dep[j][done_idx] = 1'b0;
         end
      end
      // per-entry ageing, override and dependency forcing
      for (int j = 0; j < N; j++) begin
         if (ent_ff[j].valid && ent_ff[j].qen && ent_ff[j].maxc != 8'h00) begin
            nxt_ent[j].maxc = ent_ff[j].maxc - 8'h01;
         end
         if (ent_ff[j].valid && !ent_ff[j].wr && !ent_ff[j].refr && qos_override[ent_ff[j].sel]) begin
            nxt_ent[j].minf = 1'b1;
         end
         for (int i = 0; i < N; i++) begin
            if (tany[i] && dep_ff[i][j] && ent_ff[j].valid) begin
               nxt_ent[j].forced = 1'b1;
            end
         end
      end
      // write release: full burst, last beat, full fifo, or data of another id
      if (wdat.valid) begin
         nxt_wid  = wdat.id;
         nxt_widv = 1'b1;
         for (int j = 0; j < N; j++) begin
            if (ent_ff[j].valid && ent_ff[j].wr && dep_ff[j] == '0) begin
               if ((ent_ff[j].id == wdat.id && (wdat.full_burst || wdat.last || wdat.fifo_full))
                   || (widv_ff && wdat.id != wid_ff && ent_ff[j].id == wid_ff)) begin
                  nxt_ent[j].wready = 1'b1;
               end
            end
         end
      end
      // arbitration: min time-outs, then max time-outs, then the rest
      if (!gv_ff || gnt_ready) begin
         nxt_gv = 1'b0;
         if (!pause_ff && elig != '0) begin
            if (emin != '0) begin
               pick = first_idx(emin);
            end else if (emax != '0) begin
               pick = first_idx(emax);
            end else begin
               pick = first_idx(elig);
            end
            nxt_gv = 1'b1;
            nxt_gi = pick;
            nxt_g  = '{wr: ent_ff[pick].wr, refr: ent_ff[pick].refr,
                       id: ent_ff[pick].id, chip: ent_ff[pick].chip};
            nxt_ent[pick].remain = ent_ff[pick].remain - 8'h01;
         end
      end
      // insertion: management wins, data waits in its hold stage
      slot    = first_idx(~vmask);
      ins     = (vmask != '1);
      ins_ref = ins && rreq_valid;
      if (ins_ref) begin
         rreq_ack      = 1'b1;
         rinc          = 1'b1;
         nxt_ent[slot] = '{valid: 1'b1, wr: 1'b0, refr: 1'b1, id: 8'h00, chip: rreq_chip,
                           remain: 8'h01, wready: 1'b0, qen: 1'b0, maxc: 8'h00,
                           minf: 1'b0, sel: 4'h0, forced: 1'b0};
         nxt_dep[slot] = '0;
      end else if (ins && hold_ff) begin
         nxt_hold = 1'b0;
         if (!hreq_ff.wr) begin
            s   = daq_qos_sel(hreq_ff.id, qmb_ff);
            cfg = pid_ff[s];
         end
         nxt_ent[slot] = '{valid: 1'b1, wr: hreq_ff.wr, refr: 1'b0, id: hreq_ff.id, chip: 2'h0,
                           remain: hreq_ff.bursts, wready: 1'b0,
                           qen: cfg[DAQ_PID_EN],
                           maxc: cfg[DAQ_PID_MAX_LSB +: 8],
                           minf: cfg[DAQ_PID_MIN] || (!hreq_ff.wr && qos_override[s]),
                           sel: s, forced: 1'b0};
         for (int j = 0; j < N; j++) begin
            nxt_dep[slot][j] = live[j] && !ent_ff[j].refr && ent_ff[j].wr == hreq_ff.wr
                               && ent_ff[j].id == hreq_ff.id;
         end
      end
      if (dready_ff && dreq_valid) begin
         nxt_hold = 1'b1;
         nxt_hreq = dreq;
      end
      nxt_dready = !nxt_hold;
      // refresh occupancy and its sticky time-out
      nxt_rcnt = rcnt_ff + {7'h00, rinc} - {7'h00, rdec};
      if (nxt_rcnt != 8'h00 && nxt_rcnt >= mor_ff) begin
         nxt_ref_to = 1'b1;
      end else if (nxt_rcnt == 8'h00) begin
         nxt_ref_to = 1'b0;
      end else begin
         nxt_ref_to = ref_to_ff;
      end
   end

   // entries only leave through the done port, so pause keeps them queued
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < N; i++) begin
            ent_ff[i] <= '0;
            dep_ff[i] <= '0;
         end
         hold_ff   <= 1'b0;
         hreq_ff   <= '0;
         dready_ff <= 1'b0;
         wid_ff    <= 8'h00;
         widv_ff   <= 1'b0;
         gv_ff     <= 1'b0;
         g_ff      <= '0;
         gi_ff     <= '0;
         rv_ff     <= 1'b0;
         r_ff      <= '0;
         rcnt_ff   <= 8'h00;
         ref_to_ff <= 1'b0;
      end else begin
         ent_ff    <= nxt_ent;
         dep_ff    <= nxt_dep;
         hold_ff   <= nxt_hold;
         hreq_ff   <= nxt_hreq;
         dready_ff <= nxt_dready;
         wid_ff    <= nxt_wid;
         widv_ff   <= nxt_widv;
         gv_ff     <= nxt_gv;
         g_ff      <= nxt_g;
         gi_ff     <= nxt_gi;
         rv_ff     <= nxt_rv;
         r_ff      <= nxt_r;
         rcnt_ff   <= nxt_rcnt;
         ref_to_ff <= nxt_ref_to;
      end
   end

   assign dreq_ready = dready_ff;
   assign gnt_valid  = gv_ff;
   assign gnt        = g_ff;
   assign gnt_idx    = gi_ff;
   assign rsp_valid  = rv_ff;
   assign rsp        = r_ff;
endmodule : daq_arbiter_queue

/* File: rtl/daq_pkg.sv */
// constants, field layouts and carrier types of the arbiter queue
package daq_pkg;
   localparam int          DAQ_DEPTH        = 8;
   localparam int          DAQ_IDW          = 8;
   localparam int          DAQ_NUM_PID      = 16;
   // register offsets (byte addresses); the PID page is matched against address bits [11:6]
   localparam logic [11:0] DAQ_OFF_CTRL     = 12'h000;
   localparam logic [11:0] DAQ_OFF_REFPRD   = 12'h004;
   localparam logic [11:0] DAQ_OFF_REFCFG   = 12'h008;
   localparam logic [11:0] DAQ_OFF_STATUS   = 12'h00C;
   localparam logic [11:0] DAQ_OFF_VALID    = 12'h010;
   localparam logic [5:0]  DAQ_PID_PAGE     = 6'h04;
   // field positions
   localparam int          DAQ_CTRL_PAUSE   = 4;
   localparam int          DAQ_REFCFG_CHIPS = 8;
   localparam int          DAQ_PID_EN       = 0;
   localparam int          DAQ_PID_MIN      = 1;
   localparam int          DAQ_PID_MAX_LSB  = 8;
   localparam int          DAQ_STAT_REFTO   = 8;
   localparam int          DAQ_STAT_PAUSE   = 9;
   localparam int          DAQ_STAT_RCNT    = 16;
   // reset values
   localparam logic [2:0]  DAQ_RST_QMB      = 3'h0;
   localparam logic [15:0] DAQ_RST_PRD      = 16'h0000;
   localparam logic [7:0]  DAQ_RST_MOR      = 8'h04;
   localparam logic [2:0]  DAQ_RST_CHIPS    = 3'h1;
   localparam logic [15:0] DAQ_RST_PID      = 16'h0000;

   typedef struct packed {
      logic       wr;
      logic [7:0] id;
      logic [7:0] bursts;
   } daq_dreq_s;

   typedef struct packed {
      logic       valid;
      logic [7:0] id;
      logic       full_burst;
      logic       last;
      logic       fifo_full;
   } daq_wdat_s;

   typedef struct packed {
      logic       wr;
      logic       refr;
      logic [7:0] id;
      logic [1:0] chip;
   } daq_gnt_s;

   typedef struct packed {
      logic       wr;
      logic [7:0] id;
   } daq_rsp_s;

   typedef struct packed {
      logic       valid;
      logic       wr;
      logic       refr;
      logic [7:0] id;
      logic [1:0] chip;
      logic [7:0] remain;
      logic       wready;
      logic       qen;
      logic [7:0] maxc;
      logic       minf;
      logic [3:0] sel;
      logic       forced;
   } daq_ent_s;

   // four-bit selection window out of the read ID
   function automatic logic [3:0] daq_qos_sel(input logic [7:0] id, input logic [2:0] mb);
      unique case (mb)
         3'h0:    daq_qos_sel = id[3:0];
         3'h1:    daq_qos_sel = id[4:1];
         3'h2:    daq_qos_sel = id[5:2];
         3'h3:    daq_qos_sel = id[6:3];
         default: daq_qos_sel = id[7:4];
      endcase
   endfunction : daq_qos_sel
endpackage : daq_pkg

/* File: rtl/daq_refresh_gen.sv */
// refresh period counter issuing one refresh request per active chip
module daq_refresh_gen
   import daq_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [15:0] prd,
   input  wire logic [2:0]  chips,
   output logic             req_valid,
   output logic [1:0]       req_chip,
   input  wire logic        req_ack
);
   logic [15:0] cnt_ff, nxt_cnt;
   logic [2:0]  pend_ff, nxt_pend;
   logic [1:0]  chip_ff, nxt_chip;

   assign req_valid = (pend_ff != 3'h0);
   assign req_chip  = chip_ff;

   // a zero period stops refresh; a wrap restarts the chip walk from chip 0
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_pend = pend_ff;
      nxt_chip = chip_ff;
      if (req_valid && req_ack) begin
         nxt_pend = pend_ff - 3'h1;
         nxt_chip = chip_ff + 2'h1;
      end
      if (prd != 16'h0000) begin
         if (cnt_ff == 16'h0000) begin
            nxt_cnt  = prd;
            nxt_pend = chips;
            nxt_chip = 2'h0;
         end else begin
            nxt_cnt = cnt_ff - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff  <= 16'h0000;
         pend_ff <= 3'h0;
         chip_ff <= 2'h0;
      end else begin
         cnt_ff  <= nxt_cnt;
         pend_ff <= nxt_pend;
         chip_ff <= nxt_chip;
      end
   end
endmodule : daq_refresh_gen

/* File: testbench/daq_chk_sva.sv */
// port checker for the arbiter queue
module daq_chk
   import daq_pkg::*;
#(parameter int NUM_ENTRIES = 8)(
   input wire logic                           clk,
   input wire logic                           nrst,
   input wire logic                           hsel,
   input wire logic [31:0]                    haddr,
   input wire logic [1:0]                     htrans,
   input wire logic                           hwrite,
   input wire logic                           hready,
   input wire logic [31:0]                    hrdata,
   input wire logic                           hreadyout,
   input wire logic                           hresp,
   input wire logic                           dreq_valid,
   input wire logic                           dreq_ready,
   input wire logic                           gnt_valid,
   input wire daq_gnt_s                       gnt,
   input wire logic [$clog2(NUM_ENTRIES)-1:0] gnt_idx,
   input wire logic                           gnt_ready,
   input wire logic                           done_valid,
   input wire logic                           rsp_valid
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence rd_at(logic [11:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr[11:0] == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   hready_high_a: assert property (hreadyout) else $error("wait state seen");
   okay_resp_a: assert property (!hresp) else $error("error response seen");
   unmapped_zero_a: assert property (rd_at(12'h800) |=> hrdata == 32'h0000_0000) else $error("unmapped read");
   mask_width_a: assert property (rd_at(DAQ_OFF_VALID) |=> (hrdata >> NUM_ENTRIES) == 0)
      else $error("valid mask too wide");
   take_drop_a: assert property (dreq_valid && dreq_ready |=> !dreq_ready) else $error("taken twice");
   gnt_hold_a: assert property (gnt_valid && !gnt_ready |=> gnt_valid && $stable(gnt) && $stable(gnt_idx))
      else $error("grant not held");
   rsp_cause_a: assert property (rsp_valid |-> $past(done_valid)) else $error("response without done");
   gnt_range_a: assert property (gnt_valid |-> gnt_idx < NUM_ENTRIES) else $error("index past depth");
endmodule : daq_chk

bind daq_arbiter_queue daq_chk #(.NUM_ENTRIES(NUM_ENTRIES)) daq_chk_i(.clk, .nrst, .hsel, .haddr, .htrans,
   .hwrite, .hready, .hrdata, .hreadyout, .hresp, .dreq_valid, .dreq_ready, .gnt_valid, .gnt, .gnt_idx,
   .gnt_ready, .done_valid, .rsp_valid);

/* File: testbench/daq_master_model.sv */
// request side model: one data entry request at a time
module daq_master_model
   import daq_pkg::*;
(
   input wire logic  clk,
   input wire logic  dreq_ready,
   output logic      dreq_valid,
   output daq_dreq_s dreq
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      dreq_valid = 1'b0;
      dreq = '0;
   end
   // returns once the request is taken; a caller may reuse an ID before its response
   task automatic send(input logic wr, input logic [7:0] id, output logic ok);
      int n;
      n = 0;
      dreq_valid <= 1'b1;
      dreq <= '{wr, id, 8'h01};
      @(posedge clk);
      while (!dreq_ready && n < 100) begin
         n++;
         @(posedge clk);
      end
      ok = dreq_ready;
      dreq_valid <= 1'b0;
      dreq <= ~dreq; // released bus shows the inverse, not stale data
      @(posedge clk); // lets an edge pass so a following call never re-drives valid in the same step
   endtask : send
endmodule : daq_master_model

/* File: testbench/tb_daq_arbiter_queue.sv */
// self-checking bench of the arbiter queue
module tb_daq_arbiter_queue;
   timeunit 1ns;
   timeprecision 100ps;
   import daq_pkg::*;
   logic clk, nrst, hsel, hwrite, hready, hreadyout, hresp, dreq_valid, dreq_ready, gnt_valid, gnt_ready;
   logic done_valid, rsp_valid, ok;
   logic [31:0] haddr, hwdata, hrdata, r, seed;
   logic [1:0] htrans;
   logic [2:0] hsize, gnt_idx, done_idx, i0, i1, i2;
   logic [15:0] qos_override;
   logic [7:0] id;
   daq_dreq_s dreq;
   daq_wdat_s wdat;
   daq_gnt_s gnt, g;
   daq_rsp_s rsp;
   int num_errors, checks;
   assign hready = hreadyout;
   daq_arbiter_queue #(.NUM_ENTRIES(6)) daq_arbiter_queue_i(.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .dreq_valid, .dreq, .dreq_ready, .wdat,
      .qos_override, .gnt_valid, .gnt, .gnt_idx, .gnt_ready, .done_valid, .done_idx, .rsp_valid, .rsp);
   daq_master_model daq_master_model_i(.clk, .dreq_ready, .dreq_valid, .dreq);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one single word transfer; each phase held until hready is sampled high
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0_0000, a};
      for (int p = 0; p < 2; p++) begin
         n = 0;
         @(posedge clk);
         while (!hready && n < 50) begin
            n++;
            @(posedge clk);
         end
         if (n >= 50) begin
            num_errors++;
            stop_test();
         end
         if (p == 0) begin
            htrans <= 2'b00;
            hsel <= 1'b0;
            hwdata <= d;
         end
      end
      q = hrdata;
   endtask : ahb
   task automatic take(output logic [2:0] x, output daq_gnt_s q);
      int n;
      n = 0;
      @(posedge clk);
      while (!gnt_valid && n < 200) begin
         n++;
         @(posedge clk);
      end
      if (n >= 200) begin
         num_errors++;
         stop_test();
      end
      x = gnt_idx;
      q = gnt;
      gnt_ready <= 1'b1;
      @(posedge clk);
      gnt_ready <= 1'b0;
   endtask : take
   task automatic retire(input logic [2:0] x, input logic wr, input logic [7:0] k);
      done_valid <= 1'b1;
      done_idx <= x;
      @(posedge clk);
      done_valid <= 1'b0;
      @(posedge clk);
      chk(rsp_valid, 1);
      chk(rsp, {wr, k});
   endtask : retire
   // data entry request through the partner model; a refused request ends the run
   task automatic req(input logic wr, input logic [7:0] k);
      daq_master_model_i.send(wr, k, ok);
      if (!ok) begin
         num_errors++;
         stop_test();
      end
   endtask : req
   initial begin
      seed = 32'hc0ee_0e16;
      {nrst, hsel, haddr, htrans, hwrite, hwdata, wdat, qos_override, gnt_ready, done_valid, done_idx} = '0;
      hsize = 3'h2;
      num_errors = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      ahb(0, DAQ_OFF_REFCFG, 0, r);
      chk(r, {21'h0, DAQ_RST_CHIPS, DAQ_RST_MOR});
      ahb(1, 12'h11C, 32'hFFFF_FF03, r);
      ahb(0, 12'h11C, 0, r);
      chk(r, 32'h0000_FF03);
      ahb(1, 12'h11C, 0, r);
      ahb(0, 12'h800, 0, r);
      chk(r, 0);
      // same-ID reads: the later one waits for the first to retire
      req(0, 8'h05);
      req(0, 8'h05);
      req(0, 8'h06);
      ahb(0, DAQ_OFF_VALID, 0, r);
      chk(r, 32'h0000_0007);
      take(i0, g);
      chk(g.id, 8'h05);
      take(i1, g);
      chk(g.id, 8'h06);
      retire(i0, 0, 8'h05);
      take(i2, g);
      chk(g.id, 8'h05);
      retire(i1, 0, 8'h06);
      retire(i2, 0, 8'h05);
      // write held back until its last beat arrives
      req(1, 8'h03);
      repeat (10) @(posedge clk);
      chk(gnt_valid, 0);
      wdat <= '{1'b1, 8'h03, 1'b0, 1'b1, 1'b0};
      @(posedge clk);
      wdat <= '0;
      take(i0, g);
      chk({g.wr, g.id}, 9'h103);
      retire(i0, 1, 8'h03);
      // pause holds ungranted entries until resumed
      ahb(1, DAQ_OFF_CTRL, 32'h0000_0010, r);
      req(0, 8'h09);
      repeat (10) @(posedge clk);
      chk(gnt_valid, 0);
      ahb(1, DAQ_OFF_CTRL, 0, r);
      take(i0, g);
      chk(g.id, 8'h09);
      retire(i0, 0, 8'h09);
      // window [5:2] maps id 14 to setting 5, which asks for min latency; it must jump the queue
      ahb(1, DAQ_OFF_CTRL, 32'h0000_0012, r);
      ahb(1, 12'h114, 32'h0000_0002, r);
      req(0, 8'h01);
      req(0, 8'h14);
      ahb(1, DAQ_OFF_CTRL, 0, r);
      take(i0, g);
      chk(g.id, 8'h14);
      take(i1, g);
      chk(g.id, 8'h01);
      retire(i1, 0, 8'h01);
      retire(i0, 0, 8'h14);
      ahb(1, 12'h114, 0, r);
      repeat (16) begin
         id = 8'($random(seed));
         qos_override <= 16'($random(seed));
         req(0, id);
         take(i0, g);
         chk(g.id, id);
         retire(i0, 0, id);
      end
      // one refresh from a single period wrap, tide mark at one so it times out at once
      ahb(1, DAQ_OFF_REFCFG, 32'h0000_0101, r);
      ahb(1, DAQ_OFF_REFPRD, 32'h0000_0040, r);
      ahb(1, DAQ_OFF_REFPRD, 0, r);
      ahb(0, DAQ_OFF_STATUS, 0, r);
      chk(r, 32'h0001_0101);
      take(i0, g);
      chk({g.refr, g.chip}, 3'b100);
      done_valid <= 1'b1;
      done_idx <= i0;
      @(posedge clk);
      done_valid <= 1'b0;
      @(posedge clk);
      chk(rsp_valid, 0);
      ahb(0, DAQ_OFF_STATUS, 0, r);
      chk(r, 0);
      stop_test();
   end
endmodule : tb_daq_arbiter_queue
